// ### core/pscr_lb_fifo.sv
`timescale 1ns/1ps
// elastic nibble buffer: reads wait until the fill reaches threshold
module pscr_lb_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     rstn_i,
    // fill threshold
    input  wire logic [$clog2(DEPTH):0]   thresh_i,
    // write side
    input  wire logic                     wr_valid_i,
    input  wire logic [WIDTH-1:0]         wr_data_i,
    output logic                          wr_ready_o,
    // read side
    input  wire logic                     rd_en_i,
    output logic                          rd_valid_o,
    output logic [WIDTH-1:0]              rd_data_o,
    output logic [$clog2(DEPTH):0]        level_o
);

    localparam int AW = $clog2(DEPTH);

    // pointers wrap naturally only for a power of two
    if ((1 << AW) != DEPTH || DEPTH < 2) begin : g_chk
        $error("pscr_lb_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic             armed_q;
    logic             do_wr;
    logic             do_rd;

    assign wr_ready_o = (level_o != (AW+1)'(DEPTH));
    assign do_wr      = wr_valid_i && wr_ready_o;
    assign do_rd      = rd_en_i && armed_q && (level_o != '0);

    // storage, no reset needed
    always_ff @(posedge mclk_i) begin
        if (do_wr) begin
            mem_q[wp_q] <= wr_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_q    <= '0;
            rp_q    <= '0;
            level_o <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= rp_q + 1'b1;
            end
            level_o <= level_o + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // arm at threshold, disarm once drained
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_q <= 1'b0;
        end else if (!armed_q && level_o >= thresh_i) begin
            armed_q <= 1'b1;
        end else if (armed_q && level_o == '0) begin
            armed_q <= 1'b0;
        end
    end

    // registered read port
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= '0;
        end else begin
            rd_valid_o <= do_rd;
            if (do_rd) begin
                rd_data_o <= mem_q[rp_q];
            end
        end
    end

endmodule

// ### core/pscr_pkg.sv
package pscr_pkg;

    // register index and byte address
    localparam logic [7:0]  PSCR_IDX       = 8'h11;
    localparam logic [7:0]  PSCR_ADDR      = 8'h44;
    // block state readback, index and byte address
    localparam logic [7:0]  PSTAT_IDX      = 8'h1F;
    localparam logic [7:0]  PSTAT_ADDR     = 8'h7C;

    // field positions of the control register
    localparam int          CLK_DIS_BIT    = 15;
    localparam int          PS_EN_BIT      = 14;
    localparam int          PS_MODE_LSB    = 12;
    localparam int          SCR_BYP_BIT    = 11;
    localparam int          FIFO_DEP_LSB   = 8;
    localparam int          FD_COL_BIT     = 4;
    // bits software may change; reserved and unlaid bits stay zero
    localparam logic [15:0] PSCR_WR_MASK   = 16'hFB10;
    localparam logic [15:0] PSCR_RESET     = 16'h0100;
    localparam logic [1:0]  FIFO_DEP_RESET = 2'h1;

    // axi responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // wake pulse period, 1.4 s
    localparam int          NLP_PERIOD_MS  = 1400;
    localparam int          CLK_FREQ_KHZ   = 100_000;
    localparam int          NLP_CYCLES     = NLP_PERIOD_MS * CLK_FREQ_KHZ;

    // far-end loopback fifo
    localparam int          LB_DEPTH       = 8;
    localparam int          LB_WIDTH       = 4;

    // power modes, field encoding
    typedef enum logic [1:0] {
        PSCR_MODE_NORMAL  = 2'h0,
        PSCR_MODE_PDOWN   = 2'h1,
        PSCR_MODE_ASLEEP  = 2'h2,
        PSCR_MODE_PSLEEP  = 2'h3
    } pscr_mode_t;

    // power state, gray along normal-pdown-asleep-psleep
    typedef enum logic [1:0] {
        PSCR_ST_NORMAL    = 2'b00,
        PSCR_ST_PDOWN     = 2'b01,
        PSCR_ST_ASLEEP    = 2'b11,
        PSCR_ST_PSLEEP    = 2'b10
    } pscr_state_t;

    // control register content
    typedef struct packed {
        logic        clk_dis;
        logic        ps_en;
        pscr_mode_t  ps_mode;
        logic        scr_byp;
        logic [1:0]  fifo_dep;
        logic        fd_col;
    } pscr_ctrl_t;

endpackage

// ### core/pscr_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a pin level
module pscr_sync (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    // level
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// ### core/pscr_top.sv
// Functional notes
// - clock disable bit stops internal clocks
// - clock disable acts only in power-down
// - mode 00 keeps normal full operation
// - mode 01 powers down all but management
// - active sleep sends wake pulse every 1.4s
// - passive sleep keeps energy detect, no pulses
// - energy detected in sleep wakes automatically
// - scrambler bypass bit bypasses 100M scrambler
// - reserved bits read zero, writes ignored
// - depth field resets to five nibbles
// - loopback nibbles pass through rate-adapting fifo
// - collision in full duplex only when enabled
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module pscr_top #(
    parameter int NLP_CYCLES = pscr_pkg::NLP_CYCLES,
    parameter int AW         = 8
) (
    // clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rstn_i,
    // axi4-lite write address
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [AW-1:0] s_axi_awaddr,
    // axi4-lite write data
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    // axi4-lite write response
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    output logic [1:0]         s_axi_bresp,
    // axi4-lite read address
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    input  wire logic [AW-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    // line side
    input  wire logic          energy_pin_i,
    input  wire logic          collision_i,
    input  wire logic          full_duplex_i,
    // far-end loopback
    input  wire logic          lb_enable_i,
    input  wire logic          lb_rx_valid_i,
    input  wire logic [3:0]    lb_rx_data_i,
    input  wire logic          lb_tx_en_i,
    output logic               lb_tx_valid_o,
    output logic [3:0]         lb_tx_data_o,
    // power and datapath controls
    output logic               core_power_on_o,
    output logic               clk_disable_o,
    output logic               energy_det_en_o,
    output logic               nlp_pulse_o,
    output logic               scr_bypass_o,
    output logic               col_o
);

    localparam int LBW = $clog2(pscr_pkg::LB_DEPTH);
    localparam int NCW = $clog2(NLP_CYCLES + 1);

    // the counter width and fifo depth field assume these
    if (NLP_CYCLES < 2 || pscr_pkg::LB_DEPTH < 8 || AW < 8) begin : g_chk
        $error("pscr_top: parameter out of range");
    end

    pscr_pkg::pscr_ctrl_t  ctrl_q;
    pscr_pkg::pscr_state_t state_q;
    pscr_pkg::pscr_state_t state_d;
    logic [AW-1:0]         aw_addr_q;
    logic                  aw_full_q;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic                  w_full_q;
    logic                  wr_fire;
    logic                  wr_hit;
    logic [15:0]           wr_val;
    logic [15:0]           reg_img;
    logic                  energy_s;
    logic                  wake;
    logic [NCW-1:0]        nlp_cnt_q;
    logic [LBW:0]          lb_thresh;
    logic [LBW:0]          lb_level;
    logic                  lb_fifo_valid;
    logic [3:0]            lb_fifo_data;

    // energy detect pin into the clock domain
    pscr_sync u_ed_sync (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .async_i (energy_pin_i),
        .sync_o  (energy_s)
    );

    // register image; reserved bits constant zero
    // reserved read zero
    always_comb begin
        reg_img                               = '0;
        reg_img[pscr_pkg::CLK_DIS_BIT]        = ctrl_q.clk_dis;
        reg_img[pscr_pkg::PS_EN_BIT]          = ctrl_q.ps_en;
        reg_img[pscr_pkg::PS_MODE_LSB +: 2]   = ctrl_q.ps_mode;
        reg_img[pscr_pkg::SCR_BYP_BIT]        = ctrl_q.scr_byp;
        reg_img[pscr_pkg::FIFO_DEP_LSB +: 2]  = ctrl_q.fifo_dep;
        reg_img[pscr_pkg::FD_COL_BIT]         = ctrl_q.fd_col;
    end

    // merge write data by byte lane, masked to writable bits
    always_comb begin
        wr_val = reg_img;
        if (w_strb_q[0]) begin
            wr_val[7:0] = w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
            wr_val[15:8] = w_data_q[15:8];
        end
        wr_val = wr_val & pscr_pkg::PSCR_WR_MASK;
    end

    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_hit  = (aw_addr_q[7:0] == pscr_pkg::PSCR_ADDR);

    // write address, held until the response
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_awready <= 1'b1;
            aw_full_q     <= 1'b0;
            aw_addr_q     <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_full_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            aw_full_q     <= 1'b0;
        end
    end

    // write data, either order
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_wready <= 1'b1;
            w_full_q     <= 1'b0;
            w_data_q     <= '0;
            w_strb_q     <= '0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_full_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
            w_full_q     <= 1'b0;
        end
    end

    // write response; unmapped gives slverr
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pscr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit || aw_addr_q[7:0] == pscr_pkg::PSTAT_ADDR)
                          ? pscr_pkg::RESP_OKAY : pscr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel, one cycle from address to data
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= pscr_pkg::RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= pscr_pkg::RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                pscr_pkg::PSCR_ADDR: begin
                    s_axi_rdata <= {16'h0000, reg_img};
                end
                pscr_pkg::PSTAT_ADDR: begin
                    s_axi_rdata <= {25'h000_0000, lb_level, energy_s,
                                    2'(state_q)};
                end
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= pscr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // wake on energy in either sleep
    // automatic power-up
    assign wake = energy_s && (state_q == pscr_pkg::PSCR_ST_ASLEEP
                            || state_q == pscr_pkg::PSCR_ST_PSLEEP);

    // control register; wake clears the enable, a same-cycle write wins
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q          <= '0;
            ctrl_q.fifo_dep <= pscr_pkg::FIFO_DEP_RESET;
        end else begin
            if (wake) begin
                ctrl_q.ps_en <= 1'b0;
            end
            if (wr_fire && wr_hit) begin
                ctrl_q.clk_dis  <= wr_val[pscr_pkg::CLK_DIS_BIT];
                ctrl_q.ps_en    <= wr_val[pscr_pkg::PS_EN_BIT];
                ctrl_q.ps_mode  <= pscr_pkg::pscr_mode_t'(
                                   wr_val[pscr_pkg::PS_MODE_LSB +: 2]);
                ctrl_q.scr_byp  <= wr_val[pscr_pkg::SCR_BYP_BIT];
                ctrl_q.fifo_dep <= wr_val[pscr_pkg::FIFO_DEP_LSB +: 2];
                ctrl_q.fd_col   <= wr_val[pscr_pkg::FD_COL_BIT];
            end
        end
    end

    // next power state from enable and mode
    always_comb begin
        state_d = pscr_pkg::PSCR_ST_NORMAL;
        if (ctrl_q.ps_en && !wake) begin
            unique case (ctrl_q.ps_mode)
                pscr_pkg::PSCR_MODE_NORMAL: state_d = pscr_pkg::PSCR_ST_NORMAL;
                pscr_pkg::PSCR_MODE_PDOWN:  state_d = pscr_pkg::PSCR_ST_PDOWN;
                pscr_pkg::PSCR_MODE_ASLEEP: state_d = pscr_pkg::PSCR_ST_ASLEEP;
                pscr_pkg::PSCR_MODE_PSLEEP: state_d = pscr_pkg::PSCR_ST_PSLEEP;
            endcase
        end
    end

    // power state register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= pscr_pkg::PSCR_ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // power controls, registered
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_power_on_o <= 1'b1;
            clk_disable_o   <= 1'b0;
            energy_det_en_o <= 1'b0;
        end else begin
            core_power_on_o <= (state_d == pscr_pkg::PSCR_ST_NORMAL);
            clk_disable_o   <= ctrl_q.clk_dis
                            && (state_d == pscr_pkg::PSCR_ST_PDOWN);
            energy_det_en_o <= (state_d == pscr_pkg::PSCR_ST_ASLEEP)
                            || (state_d == pscr_pkg::PSCR_ST_PSLEEP);
        end
    end

    // wake pulse timer, restarts on every entry into active sleep
    // pulse every 1.4 s
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nlp_cnt_q   <= '0;
            nlp_pulse_o <= 1'b0;
        end else if (state_d != pscr_pkg::PSCR_ST_ASLEEP) begin
            nlp_cnt_q   <= '0;
            nlp_pulse_o <= 1'b0;
        end else if (nlp_cnt_q == NCW'(NLP_CYCLES - 1)) begin
            nlp_cnt_q   <= '0;
            nlp_pulse_o <= 1'b1;
        end else begin
            nlp_cnt_q   <= nlp_cnt_q + 1'b1;
            nlp_pulse_o <= 1'b0;
        end
    end

    // datapath controls
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scr_bypass_o <= 1'b0;
            col_o        <= 1'b0;
        end else begin
            scr_bypass_o <= ctrl_q.scr_byp;
            col_o        <= collision_i
                         && (!full_duplex_i || ctrl_q.fd_col);
        end
    end

    // depth field to nibble count
    // depth decode
    always_comb begin
        unique case (ctrl_q.fifo_dep)
            2'h0:    lb_thresh = (LBW+1)'(4);
            2'h1:    lb_thresh = (LBW+1)'(5);
            2'h2:    lb_thresh = (LBW+1)'(6);
            2'h3:    lb_thresh = (LBW+1)'(8);
        endcase
    end

    // rx-to-tx rate adaptation; a nibble arriving while full is lost,
    // so software sizes the depth for packet length and clock spread
    // loopback through fifo
    pscr_lb_fifo #(
        .WIDTH (pscr_pkg::LB_WIDTH),
        .DEPTH (pscr_pkg::LB_DEPTH)
    ) u_lb_fifo (
        .mclk_i     (mclk_i),
        .rstn_i     (rstn_i),
        .thresh_i   (lb_thresh),
        .wr_valid_i (lb_rx_valid_i && lb_enable_i && core_power_on_o),
        .wr_data_i  (lb_rx_data_i),
        .wr_ready_o (),
        .rd_en_i    (lb_tx_en_i && lb_enable_i),
        .rd_valid_o (lb_fifo_valid),
        .rd_data_o  (lb_fifo_data),
        .level_o    (lb_level)
    );

    assign lb_tx_valid_o = lb_fifo_valid;
    assign lb_tx_data_o  = lb_fifo_data;

endmodule

// ### testbench/pscr_host.sv
`timescale 1ns/1ps
// management host: one register access at a time
module pscr_host (
    // clock
    input  wire logic        mclk_i,
    // write channels
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    // read channels
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    output logic [7:0]       s_axi_araddr,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp
);
    // idle bus from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = '0;
        s_axi_wdata = '0;
    end
    // released lines carry inverted leftovers, never a stale match
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [1:0] r,
                      output bit ok);
        ok = 0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(posedge mclk_i);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~v;
            end
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                ok = 1;
            end
        end
    endtask
    // read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] r, output bit ok);
        ok = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(posedge mclk_i);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid) begin
                v = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                ok = 1;
            end
        end
    endtask
endmodule

// ### testbench/pscr_props.sv
`timescale 1ns/1ps
// port-level checks on the power-save control block
module pscr_props #(
    parameter int NLP_CYCLES = 20
) (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    // register bus read side
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // line and power
    input wire logic        energy_pin_i,
    input wire logic        collision_i,
    input wire logic        full_duplex_i,
    input wire logic        core_power_on_o,
    input wire logic        clk_disable_o,
    input wire logic        energy_det_en_o,
    input wire logic        nlp_pulse_o,
    input wire logic        col_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // reads answered in every state
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    // upper half reads zero
    rd_upper_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    // clocks stop only in power-down
    clk_dis_a: assert property (
        clk_disable_o |-> !core_power_on_o && !energy_det_en_o)
        else $error("clock disable outside power-down");
    // energy detect only with core down
    sleep_off_a: assert property (
        energy_det_en_o |-> !core_power_on_o && !clk_disable_o)
        else $error("sleep with core powered");
    // one-cycle wake pulse, only with energy detect on
    nlp_once_a: assert property (
        nlp_pulse_o |-> energy_det_en_o ##1 !nlp_pulse_o)
        else $error("wake pulse malformed");
    // pulses are spaced far apart
    nlp_gap_a: assert property (
        $fell(nlp_pulse_o) |-> !nlp_pulse_o [*8])
        else $error("wake pulses too close");
    // sustained energy brings the core back
    wake_up_a: assert property (
        energy_det_en_o && energy_pin_i ##1 energy_pin_i [*5]
        |-> core_power_on_o)
        else $error("no wake on energy");
    // half duplex passes collision one cycle late
    col_half_a: assert property (
        $past(rstn_i) && !$past(full_duplex_i)
        |-> col_o == $past(collision_i))
        else $error("collision lost in half duplex");

    cover property (nlp_pulse_o);
    cover property (clk_disable_o);
    cover property (energy_det_en_o && energy_pin_i ##6 core_power_on_o);
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
    localparam int         NLP  = 20;
    localparam logic [7:0] CTRL = pscr_pkg::PSCR_ADDR;
    // design ports
    logic        mclk_i, rstn_i, energy_pin_i, collision_i, full_duplex_i;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, lb_enable_i, lb_rx_valid_i;
    logic        lb_tx_en_i, lb_tx_valid_o, core_power_on_o, clk_disable_o;
    logic        energy_det_en_o, nlp_pulse_o, scr_bypass_o, col_o;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat, d, exp;
    logic [3:0]  s_axi_wstrb, lb_rx_data_i, lb_tx_data_o, s, q[$];
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] shadow;
    int          mismatches, n_tests, i, k, n;

    pscr_top #(.NLP_CYCLES(NLP)) uut (.*);
    pscr_host host (.*);

    // 100 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        conclude();
    endtask
    task automatic wr(input logic [31:0] v, input logic [3:0] st = 4'hF,
                      input logic [7:0] a = CTRL);
        bit ok;
        host.wr(a, v, st, rsp, ok);
        if (!ok) hang();
    endtask
    task automatic rd(input logic [7:0] a = CTRL);
        bit ok;
        host.rd(a, rdat, rsp, ok);
        if (!ok) hang();
    endtask
    // waits end 1 ns past the edge
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk_i);
        #1;
    endtask
    task automatic txp();
        lb_tx_en_i <= 1'b1;
        cyc(1);
        lb_tx_en_i <= 1'b0;
    endtask
    // writable bits merged lane by lane; others read zero
    function automatic logic [31:0] exp_ctrl(logic [15:0] o,
            logic [31:0] v, logic [3:0] st);
        logic [15:0] m;
        m = {{8{st[1]}}, {8{st[0]}}};
        return {16'h0000, ((o & ~m) | (v[15:0] & m)) & 16'hFB10};
    endfunction
    function automatic int depth(int c);
        return c == 3 ? 8 : c + 4;
    endfunction
    // core on, clocks off, energy detect per mode
    function automatic logic [2:0] pw(int m);
        return m == 0 ? 3'b100 : m == 1 ? 3'b010 : 3'b001;
    endfunction

    initial begin
        void'($urandom(52871));
        {rstn_i, energy_pin_i, collision_i, full_duplex_i} = 4'h0;
        {lb_enable_i, lb_rx_valid_i, lb_tx_en_i, lb_rx_data_i} = 7'h00;
        cyc(12);
        rstn_i <= 1'b1;
        cyc(1);
        rd();
        `CHK(rdat, 32'h0000_0100)
        `CHK({core_power_on_o, clk_disable_o, energy_det_en_o}, pw(0))
        $display("reset done");
        shadow = 16'h0100;
        for (i = 0; i < 10; i++) begin
            d = $urandom();
            d[14] = 1'b0;
            s = i == 8 ? 4'h1 : i == 9 ? 4'h2 : 4'hF;
            wr(d, s);
            exp = exp_ctrl(shadow, d, s);
            shadow = exp[15:0];
            rd();
            `CHK(rdat, exp)
            `CHK(scr_bypass_o, shadow[11])
            `CHK({core_power_on_o, clk_disable_o}, 2'b10)
        end
        wr(32'hFFFF_FFFF, 4'hF, 8'h48);
        `CHK(rsp, pscr_pkg::RESP_SLVERR)
        rd(8'h40);
        `CHK({rsp, rdat}, {pscr_pkg::RESP_SLVERR, 32'h0})
        $display("registers done");
        for (i = 0; i < 8; i++) begin
            wr(32'(i[0]) << 4);
            collision_i <= i < 4 ? 1'b1 : 1'($urandom());
            full_duplex_i <= i[1];
            cyc(2);
            `CHK(col_o, collision_i & (~full_duplex_i | i[0]))
        end
        $display("collision done");
        for (i = 0; i < 4; i++) begin
            d = 32'h0000_C000 | (32'(i) << 12);
            wr(d);
            cyc(2);
            `CHK({core_power_on_o, clk_disable_o, energy_det_en_o}, pw(i))
            rd();
            `CHK(rdat, d)
        end
        for (i = 2; i < 4; i++) begin
            wr(32'h0000_4000 | (32'(i) << 12));
            n = 0;
            repeat (50) begin
                cyc(1);
                if (nlp_pulse_o === 1'b1) n++;
            end
            `CHK(n, i == 2 ? 2 : 0)
        end
        energy_pin_i <= 1'b1;
        for (k = 0; k < 10 && core_power_on_o !== 1'b1; k++) cyc(1);
        if (k == 10) hang();
        rd();
        `CHK(rdat, 32'h0000_3000)
        energy_pin_i <= 1'b0;
        $display("power done");
        lb_enable_i <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(32'(i) << 8);
            q = {};
            lb_rx_valid_i <= 1'b1;
            for (k = 0; k < depth(i); k++) begin
                q.push_back(4'($urandom()));
                lb_rx_data_i <= q[k];
                cyc(1);
                if (k == depth(i) - 2) begin
                    lb_rx_valid_i <= 1'b0;
                    cyc(3);
                    txp();
                    `CHK(lb_tx_valid_o, 1'b0)
                    lb_rx_valid_i <= 1'b1;
                end
            end
            lb_rx_valid_i <= 1'b0;
            cyc(3);
            lb_tx_en_i <= 1'b1;
            for (k = 0; k < depth(i); k++) begin
                cyc(1);
                `CHK({lb_tx_valid_o, lb_tx_data_o}, {1'b1, q[k]})
            end
            cyc(1);
            `CHK(lb_tx_valid_o, 1'b0)
            lb_tx_en_i <= 1'b0;
        end
        $display("loopback done");
        conclude();
    end
endmodule

bind pscr_top pscr_props #(.NLP_CYCLES(NLP_CYCLES)) chk (.*);
